// *** hdl/shifter_pkg.sv ***
// Purpose: shared constants and carrier types for the latched serial shifter
// Assumes: one system clock; pin-side clocks are sampled, not used as clocks
// Notes: none
`default_nettype none
package shifter_pkg;
   localparam int WIDTH = 8;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [7:0] STORE_RESET = 8'h00;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   localparam logic [1:0] CLEAR_SYNC_RESET = 2'h3;
   localparam logic [1:0] ENABLE_SYNC_RESET = 2'h3;

   typedef struct packed {
      logic serial_in;
      logic shift_clock;
      logic storage_clock;
      logic shift_clear_n;
      logic output_enable_n;
   } pins_t;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] data_oe;
      logic serial_out;
   } outs_t;
endpackage : shifter_pkg
`default_nettype wire

// *** hdl/latched_shifter.sv ***
// Purpose: serial-in shift register feeding a storage register with tri-state outputs
// Assumes: pin inputs are asynchronous to core_clk_in and are synchronised here
// Notes: clock edges are detected on synchronised pin levels, so pins must be slow
// Function
// - eight-stage shift register, one bit per shift clock, only the last stage visible directly
// - eight-bit storage register drives parallel outputs through tri-state drivers
// - shift register advances only on rising edge of its own clock
// - on shift edge without clear, stages move up, first takes serial input
// - low clear resets shift register after the pin sync delay, overrides shifting, serial output 0
// - storage clock rising edge copies whole shift register into storage
// - enable high makes parallel outputs high impedance, low drives storage contents
// - with both clocks tied, storage lags shift register by one pulse
// - serial output carries last stage for cascading
`timescale 1ns/1ps
`default_nettype none
module latched_shifter
   import shifter_pkg::*;
(
   // clock, reset, enable
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // device pins
   input wire shifter_pkg::pins_t pins_in,
   // parallel and serial outputs
   output wire shifter_pkg::outs_t outs_out
);
   import shifter_pkg::*;

   typedef struct packed {
      logic [1:0] ser_sync;
      logic [1:0] sck_sync;
      logic [1:0] rck_sync;
      logic [1:0] clr_sync;
      logic [1:0] oe_sync;
      logic sck_prev;
      logic rck_prev;
      logic [7:0] shift;
      logic [7:0] store;
   } state_t;

   state_t state_q;
   state_t state_d;
   logic sck_rise;
   logic rck_rise;
   logic clear_now;

   // the second sync stage is the only one read by logic
   assign sck_rise = state_q.sck_sync[1] & ~state_q.sck_prev;
   assign rck_rise = state_q.rck_sync[1] & ~state_q.rck_prev;
   assign clear_now = ~state_q.clr_sync[1];

   always_comb begin
      state_d = state_q;
      state_d.ser_sync = {state_q.ser_sync[0], pins_in.serial_in};
      state_d.sck_sync = {state_q.sck_sync[0], pins_in.shift_clock};
      state_d.rck_sync = {state_q.rck_sync[0], pins_in.storage_clock};
      state_d.clr_sync = {state_q.clr_sync[0], pins_in.shift_clear_n};
      state_d.oe_sync = {state_q.oe_sync[0], pins_in.output_enable_n};
      state_d.sck_prev = state_q.sck_sync[1];
      state_d.rck_prev = state_q.rck_sync[1];
      // storage samples the old shift value, giving the one-pulse lag when tied
      if (rck_rise) begin
         state_d.store = state_q.shift;
      end
      if (clear_now) begin
         state_d.shift = SHIFT_RESET;
      end else if (sck_rise) begin
         state_d.shift = {state_q.shift[6:0], state_q.ser_sync[1]};
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= '0;
         state_q.sck_sync <= SYNC_RESET;
         state_q.rck_sync <= SYNC_RESET;
         // idle pin levels, so no false edge or clear follows reset
         state_q.clr_sync <= CLEAR_SYNC_RESET;
         state_q.oe_sync <= ENABLE_SYNC_RESET;
         state_q.shift <= SHIFT_RESET;
         state_q.store <= STORE_RESET;
      end else if (clk_en_in) begin
         state_q <= state_d;
      end
   end

   // bit 0 is the first stage and first output
   assign outs_out.data = state_q.store;
   // clear acts through the sync delay; a true async clear would need a pin-clocked design
   assign outs_out.serial_out = state_q.shift[WIDTH-1] & ~clear_now;
   assign outs_out.data_oe = {8{~state_q.oe_sync[1]}};

   a_clear_zeroes_out: assert property (@(posedge core_clk_in) disable iff (reset_in)
      clear_now |-> !outs_out.serial_out)
      else $error("serial out high during clear");

   a_clear_empties: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && clear_now) |=>
      (state_q.shift == SHIFT_RESET))
      else $error("shift register not cleared");

   a_clear_pin_lat: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && !pins_in.shift_clear_n) [*2] |=>
      !outs_out.serial_out)
      else $error("clear reached serial out late");

   a_serial_rises: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $rose(outs_out.serial_out) |->
      $past(clk_en_in && sck_rise))
      else $error("serial out rose without shift");
   a_clear_keeps_store: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && clear_now && !rck_rise) |=> $stable(state_q.store))
      else $error("storage changed by clear");

   a_clear_store_rck: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && clear_now && rck_rise) |=>
      (outs_out.data == $past(state_q.shift)))
      else $error("storage lost pre-clear value");
   a_store_copies_shift: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && rck_rise) |=> (outs_out.data == $past(state_q.shift)))
      else $error("storage did not load shift value");

   a_store_bit0: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && rck_rise) |=>
      (outs_out.data[0] == $past(state_q.shift[0])))
      else $error("first output not first stage");

   a_store_bit7: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && rck_rise) |=>
      (outs_out.data[7] == $past(state_q.shift[7])))
      else $error("last output not last stage");

   a_store_reload: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && rck_rise) |=>
      (outs_out.data[7:1] == $past(state_q.shift[7:1])))
      else $error("storage upper bits not loaded");

   a_rck_single: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && rck_rise) |=>
      !rck_rise)
      else $error("storage edge seen twice");
   a_shift_moves_up: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && sck_rise && !clear_now) |=>
      (state_q.shift == {$past(state_q.shift[6:0]), $past(state_q.ser_sync[1])}))
      else $error("shift step wrong");

   a_first_stage: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && sck_rise && !clear_now) |=>
      (state_q.shift[0] == $past(state_q.ser_sync[1])))
      else $error("first stage missed serial bit");

   a_shift_top: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && sck_rise && !clear_now) |=>
      (state_q.shift[7] == $past(state_q.shift[6])))
      else $error("last stage missed its neighbour");

   a_sck_single: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && sck_rise) |=>
      !sck_rise)
      else $error("shift edge seen twice");
   a_shift_holds_idle: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && !sck_rise && !clear_now) |=> $stable(state_q.shift))
      else $error("shift moved without edge");

   a_rck_no_shift: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && rck_rise && !sck_rise && !clear_now) |=>
      $stable(state_q.shift))
      else $error("storage edge moved shift register");

   a_freeze_state: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !clk_en_in |=>
      $stable(state_q))
      else $error("state moved while disabled");

   a_shift_changed: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $changed(state_q.shift) |->
      $past(clk_en_in && (sck_rise || clear_now)))
      else $error("shift changed without cause");
   a_oe_follows_pin: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && !pins_in.output_enable_n) [*3] |-> (outs_out.data_oe == 8'hff))
      else $error("outputs not enabled");

   a_oe_off_pin: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && pins_in.output_enable_n) [*3] |->
      (outs_out.data_oe == 8'h00))
      else $error("outputs not released");

   a_oe_all_bits: assert property (@(posedge core_clk_in) disable iff (reset_in)
      clk_en_in |->
      (outs_out.data_oe == {8{outs_out.data_oe[0]}}))
      else $error("output enables disagree");

   a_oe_changed: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $changed(outs_out.data_oe) |->
      $past(clk_en_in))
      else $error("enable moved while disabled");
   a_serial_last_stage: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !clear_now |-> (outs_out.serial_out == state_q.shift[7]))
      else $error("serial out not last stage");

   a_lag_tied: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && rck_rise && sck_rise && !clear_now) |=>
      (outs_out.data[6:0] == state_q.shift[7:1]))
      else $error("storage not one pulse behind");
   a_store_holds_idle: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (clk_en_in && !rck_rise) |=> $stable(outs_out.data))
      else $error("storage moved without edge");

   // only a storage edge may move the parallel data outputs, whatever the pins do
   a_rck_edge: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $changed(outs_out.data) |->
      $past(clk_en_in && rck_rise))
      else $error("storage changed without edge");

   // two edges in reset, since the first may be the one that applies it
   a_reset_idle: assert property (@(posedge core_clk_in)
      reset_in [*2] |->
      (outs_out.data == STORE_RESET && outs_out.data_oe == 8'h00 && !outs_out.serial_out))
      else $error("outputs not idle in reset");
endmodule : latched_shifter
`default_nettype wire

// *** tb/pin_driver.sv ***
// Purpose: model of the logic that drives the shifter pins
// Assumes: every pin level is held at least 4 cycles
// Notes: the data line is inverted once its hold has run out
`timescale 1ns/1ps
`default_nettype none
module pin_driver
   import shifter_pkg::*;
(
   // clock and pins
   input wire logic clk_in,
   output var shifter_pkg::pins_t pins_out
);
   initial pins_out = 5'h03;
   task automatic pulse(input logic shf, input logic sto, input logic d);
      pins_out.serial_in = d;
      repeat (4) @(negedge clk_in);
      pins_out.shift_clock = shf;
      pins_out.storage_clock = sto;
      repeat (4) @(negedge clk_in);
      pins_out.shift_clock = 1'b0;
      pins_out.storage_clock = 1'b0;
      pins_out.serial_in = ~d;
      repeat (4) @(negedge clk_in);
   endtask : pulse
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) pulse(1'b1, 1'b0, b[i]);
      pulse(1'b0, 1'b1, 1'b0);
   endtask : send_byte
endmodule : pin_driver
`default_nettype wire

// *** tb/test_serial_to_parallel_latched_shifter.sv ***
// Purpose: self-checking bench for the latched shifter
// Assumes: pins change at the falling edge, via pin_driver
// Notes: clock enable dropped once to check that state freezes
`timescale 1ns/1ps
`default_nettype none
module test_serial_to_parallel_latched_shifter;
   import shifter_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   pins_t pins;
   outs_t outs;
   int mismatches = 0, n_tests = 0, cycles = 0;
   logic [16:0] rows [3] = '{{8'ha5, 1'b0, 8'hff}, {8'h3c, 1'b1, 8'h00}, {8'h81, 1'b0, 8'hff}};
   pin_driver drv (.clk_in(clk), .pins_out(pins));
   latched_shifter dut (.core_clk_in(clk), .reset_in(rst), .clk_en_in(en), .pins_in(pins),
      .outs_out(outs));
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      foreach (rows[i]) begin
         drv.pins_out.output_enable_n = rows[i][8];
         drv.send_byte(rows[i][16:9]);
         check("data", rows[i][16:9], outs.data);
         check("oe", rows[i][7:0], outs.data_oe);
         check("serial", {7'h0, rows[i][16]}, {7'h0, outs.serial_out});
         $display("row %0d done", i);
      end
      // shifting while clear is low must be ignored
      drv.pins_out.shift_clear_n = 1'b0;
      drv.pulse(1'b1, 1'b0, 1'b1);
      check("clr serial", 8'h00, {7'h0, outs.serial_out});
      check("clr data", 8'h81, outs.data);
      drv.pins_out.shift_clear_n = 1'b1;
      drv.pulse(1'b0, 1'b1, 1'b0);
      check("clr store", 8'h00, outs.data);
      drv.pulse(1'b1, 1'b1, 1'b1);
      check("tied 1", 8'h00, outs.data);
      drv.pulse(1'b1, 1'b1, 1'b0);
      check("tied 2", 8'h01, outs.data);
      $display("clear and tied clock tests done");
      // edges given while disabled must be lost, not stored
      en = 1'b0;
      drv.pulse(1'b1, 1'b1, 1'b1);
      en = 1'b1;
      repeat (4) @(negedge clk);
      check("frozen", 8'h01, outs.data);
      // reset in mid-run, then a byte straight after release
      rst = 1'b1;
      @(negedge clk);
      check("rst data", 8'h00, outs.data);
      check("rst oe", 8'h00, outs.data_oe);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      check("oe back", 8'hff, outs.data_oe);
      check("rst serial", 8'h00, {7'h0, outs.serial_out});
      drv.send_byte(8'h5a);
      check("after rst", 8'h5a, outs.data);
      $display("freeze and reset tests done");
      report_and_stop();
   end
endmodule : test_serial_to_parallel_latched_shifter
`default_nettype wire
